//--- display_hw_reset_sequencer.v
// Hardware reset sequencer: pin filter, blanking, settings reload and command gating.
// Functional notes
// - Low pulses on the reset pin shorter than 5 us are ignored and pulses longer than 9 us always reset.
// - The same spike filter acts while a valid reset pulse is held, so short high glitches do not end it.
// - Each reset release reloads identification, common electrode voltage and other settings: within 5 ms from display-off, after 120 ms from awake.
// - A reset taken in the low-power display-off state finishes its release sequence within 5 ms.
// - A reset taken in the awake state finishes its release sequence 6 cycles after its 120 ms blanking.
// - A reset that starts in the awake state runs a blanking sequence of no more than 120 ms.
// - A reset taken in the low-power display-off state holds display_blank from pulse acceptance until the reload ends.
// - At reset release defaults_load pulses for one cycle and the id and settings registers are reloaded from the store.
`timescale 1ns/1ns
`include "rst_seq_defs.vh"

module display_hw_reset_sequencer
(
    // Clock and chip reset
    input  wire        clk,
    input  wire        rst_n,
    // Host reset pin, taken as synchronous
    input  wire        hw_reset_n_pin,
    // Panel power state before reset: 1 awake, 0 low-power display-off
    input  wire        panel_awake,
    // Host command stream
    input  wire        cmd_valid,
    input  wire [7:0]  cmd_data,
    // Non-volatile settings read port
    input  wire [7:0]  nvm_rdata,
    // Outputs
    output reg         cmd_out_valid,
    output reg  [7:0]  cmd_out_data,
    output reg         not_ready,
    output reg         display_blank,
    output reg         defaults_load,
    output reg         nvm_rd,
    output reg  [1:0]  nvm_addr,
    output reg  [7:0]  id_byte,
    output reg  [7:0]  common_electrode_voltage_setting,
    output reg  [7:0]  misc_setting,
    output reg         seq_busy
);

////////////////////////////////////////////////////////////////////////////////

reg  [2:0]         state_r;
reg  [2:0]         state_nxt;
reg  [`FILT_W-1:0] low_cnt_r;
reg  [`FILT_W-1:0] high_cnt_r;
reg  [`SEQ_W-1:0]  seq_cnt_r;
reg                awake_r;
reg  [2:0]         rd_step_r;

function [`SEQ_W-1:0] inc_seq;
    input [`SEQ_W-1:0] v;
    begin
        inc_seq = v + {{(`SEQ_W-1){1'b0}}, 1'b1};
    end
endfunction

wire pulse_accept = (low_cnt_r >= `RESET_ACCEPT_CYC);
wire pin_released = (high_cnt_r >= `SPIKE_REJECT_CYC);
wire pulse_start  = (low_cnt_r >= `SPIKE_REJECT_CYC);
wire blank_done   = (seq_cnt_r >= `AWAKE_RELEASE_CYC - 1);
wire reload_done  = (rd_step_r == 3'h5);

////////////////////////////////////////////////////////////////////////////////
// Pin filter: counts saturate; outside the run state the low count holds through a short high glitch, but any low sample clears the high count.

always @(posedge clk)
begin
    if (!rst_n)
    begin
        low_cnt_r  <= {`FILT_W{1'b0}};
        high_cnt_r <= {`FILT_W{1'b0}};
    end
    else if (!hw_reset_n_pin)
    begin
        high_cnt_r <= {`FILT_W{1'b0}};
        if (!pulse_accept)
            low_cnt_r <= low_cnt_r + 1'b1;
    end
    else
    begin
        if (!pin_released)
            high_cnt_r <= high_cnt_r + 1'b1;
        if (state_r == `ST_RUN || pin_released)
            low_cnt_r <= {`FILT_W{1'b0}};
    end
end

////////////////////////////////////////////////////////////////////////////////

always @*
begin
    state_nxt = state_r;
    case (state_r)
        `ST_RUN:
            if (pulse_start)
                state_nxt = `ST_PULSE;
        `ST_PULSE:
            if (pulse_accept)
                state_nxt = `ST_HOLD;
            else if (pin_released)
                state_nxt = `ST_RUN;
        `ST_HOLD:
            if (pin_released)
                state_nxt = awake_r ? `ST_BLANK : `ST_RELOAD;
        `ST_BLANK:
            if (blank_done)
                state_nxt = `ST_RELOAD;
        `ST_RELOAD:
            if (reload_done)
                state_nxt = `ST_RUN;
        default:
            state_nxt = `ST_RUN;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Blanking runs first from the awake state, so the reload ends 6 cycles after the 120 ms blanking.

always @(posedge clk)
begin
    if (!rst_n)
    begin
        state_r       <= `ST_RUN;
        seq_cnt_r     <= {`SEQ_W{1'b0}};
        awake_r       <= 1'b0;
        rd_step_r     <= 3'h0;
        nvm_rd        <= 1'b0;
        nvm_addr      <= 2'h0;
        id_byte       <= 8'h00;
        common_electrode_voltage_setting <= 8'h00;
        misc_setting  <= 8'h00;
        not_ready     <= 1'b1;
        display_blank <= 1'b1;
        defaults_load <= 1'b0;
        seq_busy      <= 1'b1;
        cmd_out_valid <= 1'b0;
        cmd_out_data  <= 8'h00;
    end
    else
    begin
        state_r       <= state_nxt;
        defaults_load <= 1'b0;
        nvm_rd        <= 1'b0;
        if (state_r == `ST_RUN && pulse_start)
            awake_r <= panel_awake;
        if (state_r == `ST_BLANK)
            seq_cnt_r <= inc_seq(seq_cnt_r);
        else
            seq_cnt_r <= {`SEQ_W{1'b0}};
        if (state_r == `ST_HOLD && pin_released)
        begin
            defaults_load <= 1'b1;
            rd_step_r     <= 3'h0;
        end
        if (state_r == `ST_RELOAD && !reload_done)
        begin
            // The store registers its answer on the edge after the strobe, so each byte
            // is taken two steps after its read was issued.
            rd_step_r <= rd_step_r + 3'h1;
            nvm_rd    <= (rd_step_r < 3'h3);
            nvm_addr  <= rd_step_r[1:0];
            case (rd_step_r)
                3'h2: id_byte <= nvm_rdata;
                3'h3: common_electrode_voltage_setting <= nvm_rdata;
                3'h4: misc_setting <= nvm_rdata;
                default: ;
            endcase
        end
        not_ready     <= (state_nxt != `ST_RUN);
        seq_busy      <= (state_nxt != `ST_RUN);
        display_blank <= (state_nxt == `ST_HOLD || state_nxt == `ST_BLANK
                          || state_nxt == `ST_RELOAD);
        cmd_out_valid <= cmd_valid && (state_r == `ST_RUN) && !pulse_start;
        if (cmd_valid && state_r == `ST_RUN)
            cmd_out_data <= cmd_data;
    end
end

endmodule

//--- nvm_model.sv
// Settings store model answering one cycle after each read.
`timescale 1ns/1ns
module nvm_model
(
    input wire logic       clk,
    input wire logic       nvm_rd,
    input wire logic [1:0] nvm_addr,
    output logic     [7:0] nvm_rdata
);
    initial nvm_rdata = 8'h00;
    // Outside the answer cycle the data toggles so stale values are never trusted.
    always @(posedge clk)
        nvm_rdata <= nvm_rd ? (8'h5a ^ {6'h00, nvm_addr}) : ~nvm_rdata;
endmodule

//--- reset_seq_asserts.sv
// Port-level checks for the display hardware reset sequencer.
`timescale 1ns/1ns
module reset_seq_asserts
(
    // Clock, reset and host side
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hw_reset_n_pin,
    input wire logic panel_awake,
    input wire logic cmd_valid,
    // Sequencer outputs
    input wire logic cmd_out_valid,
    input wire logic not_ready,
    input wire logic display_blank,
    input wire logic defaults_load,
    input wire logic nvm_rd,
    input wire logic seq_busy
);
    logic [7:0] low_r;
    logic [7:0] high_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Run lengths of the pin saturate so a long pulse never wraps.
    always @(posedge clk)
    begin
        low_r  <= hw_reset_n_pin ? 8'h00 : low_r + {7'h0, low_r != 8'hff};
        high_r <= !hw_reset_n_pin ? 8'h00 : high_r + {7'h0, high_r != 8'hff};
    end
    spike_reject_a: assert property ($rose(not_ready) |-> low_r > 8'd97) else $error("short low");
    long_pulse_a: assert property (low_r == 8'd200 |-> not_ready) else $error("missed");
    release_filt_a: assert property (defaults_load |-> high_r > 8'd97) else $error("early");
    load_blank_a: assert property (defaults_load |-> display_blank && not_ready) else $error("bl");
    reload_bound_a: assert property (defaults_load && !panel_awake |-> ##[1:1000] !not_ready)
        else $error("slow reload");
    awake_blank_a: assert property (defaults_load && panel_awake |=> display_blank [*8])
        else $error("no blanking");
    reload_ready_a: assert property (nvm_rd |-> not_ready) else $error("read when ready");
    cmd_gate_a: assert property (cmd_out_valid |-> $past(cmd_valid) && !$past(not_ready))
        else $error("command leaked");
    busy_same_a: assert property (seq_busy == not_ready) else $error("busy differs");
    cover property (defaults_load && !panel_awake);
    cover property (defaults_load && panel_awake);
    cover property (cmd_valid && not_ready);
endmodule
bind display_hw_reset_sequencer reset_seq_asserts chk_i (.clk(clk), .rst_n(rst_n),
    .hw_reset_n_pin(hw_reset_n_pin), .panel_awake(panel_awake), .cmd_valid(cmd_valid),
    .cmd_out_valid(cmd_out_valid), .not_ready(not_ready), .display_blank(display_blank),
    .defaults_load(defaults_load), .nvm_rd(nvm_rd), .seq_busy(seq_busy));

//--- rst_seq_defs.vh
// Timing constants and state codes for the display hardware reset sequencer.
`ifndef RST_SEQ_DEFS_VH
`define RST_SEQ_DEFS_VH

// Clock period in nanoseconds (20 MHz).
`define CLK_PERIOD_NS      50
// Spike rejection bound in us; shorter low pulses are ignored.
`define SPIKE_REJECT_US    5
// Low pulse width in us beyond which a full reset is certain.
`define RESET_ACCEPT_US    9
// Settings reload and command lockout time in ms.
`define RELOAD_MS          5
// Release latency and blanking limit from the awake state in ms.
`define AWAKE_RELEASE_MS   120

// Cycle counts derived from the times above.
`define SPIKE_REJECT_CYC   ((`SPIKE_REJECT_US * 1000) / `CLK_PERIOD_NS)
`define RESET_ACCEPT_CYC   ((`RESET_ACCEPT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RELOAD_CYC         ((`RELOAD_MS * 1000000) / `CLK_PERIOD_NS)
`define AWAKE_RELEASE_CYC  ((`AWAKE_RELEASE_MS * 1000000) / `CLK_PERIOD_NS)

// Counter widths.
`define FILT_W             9
`define SEQ_W              22

// Sequencer state codes.
`define ST_RUN             3'h0
`define ST_PULSE           3'h1
`define ST_HOLD            3'h2
`define ST_RELOAD          3'h3
`define ST_BLANK           3'h4

`endif

//--- tb_top.sv
// Self-checking bench for the display hardware reset sequencer.
`timescale 1ns/1ns
module tb_top;
    logic clk = 0, rst_n = 0, pin = 1, aw = 0, cv = 0;
    logic [7:0] cd = 8'h00, rd, od, idb, vc, ms;
    logic ov, nr, bl, dl, nrd, busy;
    logic [1:0] na;
    int fail_count = 0, checks = 0, i;
    always #25 clk = ~clk;
    display_hw_reset_sequencer dut (.clk(clk), .rst_n(rst_n), .hw_reset_n_pin(pin),
        .panel_awake(aw), .cmd_valid(cv), .cmd_data(cd), .nvm_rdata(rd), .cmd_out_valid(ov),
        .cmd_out_data(od), .not_ready(nr), .display_blank(bl), .defaults_load(dl),
        .nvm_rd(nrd), .nvm_addr(na), .id_byte(idb), .common_electrode_voltage_setting(vc),
        .misc_setting(ms), .seq_busy(busy));
    nvm_model nvm (.clk(clk), .nvm_rd(nrd), .nvm_addr(na), .nvm_rdata(rd));
    task tally_and_finish;
        if (fail_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic c);
        checks++;
        if (c !== 1'b1)
        begin
            fail_count++;
            $display("Error at %0t: output mismatch", $time);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task send(input logic [7:0] d, input logic pass);
        @(posedge clk);
        cd <= d;
        cv <= 1;
        cyc(1);
        cv <= 0;
        @(negedge clk);
        chk(ov === pass && (!pass || od === d));
        cyc(1);
    endtask
    task t_spike;
        pin <= 0;
        cyc(90);
        pin <= 1;
        cyc(150);
        chk(nr === 1'b0);
        send(8'h3c, 1);
    endtask
    task t_low_power;
        pin <= 0;
        cyc(150);
        pin <= 1;
        cyc(10);
        pin <= 0;
        cyc(60);
        pin <= 1;
        cyc(20);
        chk(nr === 1'b1 && bl === 1'b1);
        send(8'h11, 0);
        for (i = 0; i < 3000 && nr !== 1'b0; i++) @(negedge clk);
        if (i == 3000)
        begin
            fail_count++;
            $display("Error at %0t: reload never finished", $time);
            tally_and_finish;
        end
        @(negedge clk);
        chk(bl === 1'b0 && idb === 8'h5a && vc === 8'h5b && ms === 8'h58);
        send(8'h29, 1);
    endtask
    task t_awake;
        aw <= 1;
        pin <= 0;
        cyc(220);
        pin <= 1;
        cyc(400);
        // No wake command is issued while the release latency runs.
        chk(bl === 1'b1 && nr === 1'b1);
        rst_n <= 0;
        cyc(6);
        rst_n <= 1;
        cyc(2);
        @(negedge clk);
        chk(nr === 1'b0 && bl === 1'b0);
        send(8'h42, 1);
    endtask
    initial
    begin
        cyc(6);
        rst_n <= 1;
        cyc(3);
        t_spike;
        t_low_power;
        t_awake;
        tally_and_finish;
    end
endmodule
